// ===== bpbs_sequencer.sv
`include "bpbs_regs.svh"

module bpbs_sequencer
  import bpbs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Motion feedback pins
  input  wire logic        zero_mark_pin,
  input  wire logic        reversing_cam_pin,
  input  wire logic        referencing_cam_pin,
  input  wire logic        ref_coord_reached_pin,
  input  wire logic        braking_point_pin,
  input  wire logic        in_position_window_pin,
  input  wire logic        standstill_pin,
  input  wire logic        dir_change_needed_pin,
  input  wire logic        ext_block_change_pin,
  input  wire logic        extended_telegram,
  // Motion command outputs
  output logic             move_enable,
  output logic             move_negative,
  output logic      [31:0] move_speed,
  output logic             stop_cams_enable,
  output logic             direct_setpoint_input,
  output logic      [31:0] block_target_position,
  output bpbs_pkg::bpbs_pmode_t block_pos_mode,
  output bpbs_pkg::bpbs_task_t  block_task_code,
  output logic      [3:0]  active_block,
  output logic             reference_point_reached,
  output logic             missing_external_change_alarm
);

  import bpbs_pkg::*;

  logic [15:0] drive_control_word_q;
  logic [15:0] block_select_word_q;
  logic        search_start_direction_q;
  logic        reversing_cam_enable_q;
  logic        alarm_is_fault_q;
  logic [31:0] zero_mark_search_speed_q;
  logic [31:0] reference_approach_speed_q;
  logic [31:0] reference_coordinate_q;
  logic [31:0] reference_offset_q;
  logic [3:0]  task_code_q   [`BPBS_NUM_BLOCKS];
  logic [15:0] task_mode_q   [`BPBS_NUM_BLOCKS];
  logic [31:0] target_q      [`BPBS_NUM_BLOCKS];

  bpbs_home_t  home_q;
  bpbs_blk_t   blk_q;
  logic        home_dir_q;
  logic        home_start_prev_q;
  logic        activate_prev_q;
  logic [15:0] cur_mode_q;
  logic [3:0]  cur_idx_q;
  logic        ext_edge_seen_q;

  // Two-stage synchronisers for all pins
  localparam int NPIN = 9;
  logic [NPIN-1:0] pin_raw, pin_s1_q, pin_s2_q, pin_s3_q;
  assign pin_raw = {ext_block_change_pin, dir_change_needed_pin, standstill_pin,
                    in_position_window_pin, braking_point_pin, ref_coord_reached_pin,
                    referencing_cam_pin, reversing_cam_pin, zero_mark_pin};

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end
    else if (clk_en)
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic zmark, rev_cam, ref_cam, ref_reached_pos, brake_pt, in_win, still, dir_chg, ext_edge;
  assign zmark           = pin_s2_q[0];
  assign rev_cam         = pin_s2_q[1];
  assign ref_cam         = pin_s2_q[2];
  assign ref_reached_pos = pin_s2_q[3];
  assign brake_pt        = pin_s2_q[4];
  assign in_win          = pin_s2_q[5];
  assign still           = pin_s2_q[6];
  assign dir_chg         = pin_s2_q[7];
  assign ext_edge        = pin_s2_q[8] & ~pin_s3_q[8];

  // Speed clamp to the legal range
  function automatic logic [31:0] clamp_speed(input logic [31:0] v);
    if (v == 32'h0)
      clamp_speed = 32'h1;
    else if (v > `BPBS_SPEED_MAX)
      clamp_speed = `BPBS_SPEED_MAX;
    else
      clamp_speed = v;
  endfunction

  function automatic logic [3:0] cont_of(input logic [15:0] m);
    cont_of = m[`BPBS_MODE_CONT_LSB +: 4];
  endfunction

  logic home_start, activate, wr_go;
  assign home_start = drive_control_word_q[`BPBS_CW_HOME_START];
  assign activate   = drive_control_word_q[`BPBS_CW_ACTIVATE];
  assign wr_go      = clk_en & reg_wr;

  // Control and configuration registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      drive_control_word_q       <= 16'h0;
      block_select_word_q        <= 16'h0;
      search_start_direction_q   <= 1'b0;
      reversing_cam_enable_q     <= 1'b1;
      alarm_is_fault_q           <= 1'b0;
      zero_mark_search_speed_q   <= `BPBS_SPEED_DEFAULT;
      reference_approach_speed_q <= `BPBS_SPEED_DEFAULT;
      reference_coordinate_q     <= 32'h0;
      reference_offset_q         <= 32'h0;
    end
    else if (wr_go)
    begin
      unique case (reg_addr)
        `BPBS_ADDR_CTRL:     drive_control_word_q <= reg_wdata[15:0];
        `BPBS_ADDR_BLKSEL:   block_select_word_q <= reg_wdata[15:0];
        `BPBS_ADDR_HCFG:
        begin
          search_start_direction_q <= reg_wdata[0];
          reversing_cam_enable_q   <= reg_wdata[1];
          alarm_is_fault_q         <= reg_wdata[2];
        end
        `BPBS_ADDR_ZSPEED:   zero_mark_search_speed_q <= clamp_speed(reg_wdata);
        `BPBS_ADDR_RSPEED:   reference_approach_speed_q <= clamp_speed(reg_wdata);
        `BPBS_ADDR_REFCOORD: reference_coordinate_q <= reg_wdata;
        `BPBS_ADDR_REFOFS:   reference_offset_q <= reg_wdata;
        default:             ;
      endcase
    end
  end

  // Block table storage
  genvar gi;
  generate
    for (gi = 0; gi < `BPBS_NUM_BLOCKS; gi++)
    begin : g_blk
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          task_code_q[gi] <= 4'h0;
          task_mode_q[gi] <= 16'h0;
          target_q[gi]    <= 32'h0;
        end
        else if (wr_go)
        begin
          if (reg_addr == (`BPBS_ADDR_TASK_BASE + 8'(gi)))
            task_code_q[gi] <= reg_wdata[3:0];
          if (reg_addr == (`BPBS_ADDR_MODE_BASE + 8'(gi)))
            task_mode_q[gi] <= {4'h0, reg_wdata[11:0]};
          if (reg_addr == (`BPBS_ADDR_TARGET_BASE + 8'(gi)))
            target_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Homing sequencer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      home_q            <= BPBS_H_IDLE;
      home_dir_q        <= 1'b0;
      home_start_prev_q <= 1'b0;
      stop_cams_enable  <= 1'b1;
    end
    else if (clk_en)
    begin
      home_start_prev_q <= home_start;
      unique case (home_q)
        BPBS_H_IDLE:
          if (home_start && !home_start_prev_q)
          begin
            home_q     <= BPBS_H_SEARCH;
            home_dir_q <= search_start_direction_q;
            if (!extended_telegram)
              stop_cams_enable <= 1'b0;
          end
        BPBS_H_SEARCH:
          if (!home_start)
            home_q <= BPBS_H_ABORT;
          else if (zmark)
            home_q <= BPBS_H_APPR;
          else if (rev_cam && reversing_cam_enable_q)
            home_dir_q <= ~search_start_direction_q;
        BPBS_H_APPR:
          if (!home_start)
            home_q <= BPBS_H_ABORT;
          else if (ref_reached_pos)
            home_q <= BPBS_H_DONE;
        BPBS_H_DONE:
          if (!home_start)
            home_q <= BPBS_H_IDLE;
        BPBS_H_ABORT:
          home_q <= BPBS_H_IDLE;
        default:
          home_q <= BPBS_H_IDLE;
      endcase
      // the extended telegram leaves the stop cams to the controller
      if (!extended_telegram && home_q != BPBS_H_IDLE && ref_cam)
        stop_cams_enable <= 1'b1;
      else if (!extended_telegram && home_q == BPBS_H_ABORT)
        stop_cams_enable <= 1'b1;
    end
  end

  // Traversing block engine
  logic [3:0] sel_idx;
  logic       direct_sel;
  assign sel_idx    = block_select_word_q[3:0];
  assign direct_sel = block_select_word_q[`BPBS_BS_DIRECT];

  logic advance;
  always_comb
  begin
    advance = 1'b0;
    unique case (cont_of(cur_mode_q))
      BPBS_C_STOP:      advance = still && in_win;
      BPBS_C_FLY:       advance = dir_chg ? (still && in_win) : brake_pt;
      BPBS_C_EXT:       advance = ext_edge || brake_pt;
      BPBS_C_EXT_WAIT:  advance = ext_edge || ext_edge_seen_q;
      BPBS_C_EXT_ALARM: advance = ext_edge || ext_edge_seen_q;
      default:          advance = 1'b0;
    endcase
  end

  logic [3:0] nxt_idx;
  assign nxt_idx = cur_idx_q + 4'h1;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      blk_q                         <= BPBS_B_IDLE;
      activate_prev_q               <= 1'b0;
      cur_idx_q                     <= 4'h0;
      cur_mode_q                    <= 16'h0;
      ext_edge_seen_q               <= 1'b0;
      missing_external_change_alarm <= 1'b0;
      block_target_position         <= 32'h0;
      block_pos_mode                <= BPBS_P_ABSOLUTE;
      block_task_code               <= BPBS_T_NONE;
    end
    else if (clk_en)
    begin
      activate_prev_q <= activate;
      if (ext_edge)
        ext_edge_seen_q <= 1'b1;
      unique case (blk_q)
        BPBS_B_IDLE, BPBS_B_END:
          if (activate && !activate_prev_q && !direct_sel && !task_mode_q[sel_idx][`BPBS_MODE_HIDE])
          begin
            blk_q                         <= BPBS_B_RUN;
            cur_idx_q                     <= sel_idx;
            cur_mode_q                    <= task_mode_q[sel_idx];
            block_target_position         <= target_q[sel_idx];
            block_pos_mode                <= bpbs_pmode_t'(task_mode_q[sel_idx][`BPBS_MODE_POS_LSB +: 4]);
            block_task_code               <= bpbs_task_t'(task_code_q[sel_idx]);
            ext_edge_seen_q               <= ext_edge;
            missing_external_change_alarm <= 1'b0;
          end
        BPBS_B_RUN:
          if (!activate || direct_sel)
            blk_q <= BPBS_B_IDLE;
          else if (cont_of(cur_mode_q) == BPBS_C_END && still && in_win)
            blk_q <= BPBS_B_END;
          else if (advance)
          begin
            cur_idx_q             <= nxt_idx;
            cur_mode_q            <= task_mode_q[nxt_idx];
            block_target_position <= target_q[nxt_idx];
            block_pos_mode        <= bpbs_pmode_t'(task_mode_q[nxt_idx][`BPBS_MODE_POS_LSB +: 4]);
            block_task_code       <= bpbs_task_t'(task_code_q[nxt_idx]);
            ext_edge_seen_q       <= 1'b0;
          end
          else if (still && (cont_of(cur_mode_q) == BPBS_C_EXT_WAIT ||
                             cont_of(cur_mode_q) == BPBS_C_EXT_ALARM))
          begin
            blk_q <= BPBS_B_HOLD;
            if (cont_of(cur_mode_q) == BPBS_C_EXT_ALARM)
              missing_external_change_alarm <= 1'b1;
          end
        BPBS_B_HOLD:
          if (!activate || (missing_external_change_alarm && alarm_is_fault_q))
            blk_q <= BPBS_B_IDLE;
          else if (ext_edge)
          begin
            blk_q                 <= BPBS_B_RUN;
            cur_idx_q             <= nxt_idx;
            cur_mode_q            <= task_mode_q[nxt_idx];
            block_target_position <= target_q[nxt_idx];
            block_pos_mode        <= bpbs_pmode_t'(task_mode_q[nxt_idx][`BPBS_MODE_POS_LSB +: 4]);
            block_task_code       <= bpbs_task_t'(task_code_q[nxt_idx]);
            ext_edge_seen_q       <= 1'b0;
          end
        default:
          blk_q <= BPBS_B_IDLE;
      endcase
    end
  end

  // Motion command and status outputs
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      move_enable             <= 1'b0;
      move_negative           <= 1'b0;
      move_speed              <= 32'h0;
      reference_point_reached <= 1'b0;
      direct_setpoint_input   <= 1'b0;
      active_block            <= 4'h0;
    end
    else if (clk_en)
    begin
      move_enable             <= (home_q == BPBS_H_SEARCH) || (home_q == BPBS_H_APPR) || (blk_q == BPBS_B_RUN);
      move_negative           <= home_dir_q;
      move_speed              <= (home_q == BPBS_H_APPR) ? reference_approach_speed_q
                                                         : zero_mark_search_speed_q;
      reference_point_reached <= (home_q == BPBS_H_DONE);
      direct_setpoint_input   <= direct_sel;
      active_block            <= cur_idx_q;
    end
  end

  // Register read, data in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h0;
    else if (clk_en)
    begin
      reg_rdata <= 32'h0;
      if (reg_rd)
      begin
        if (reg_addr[7:4] == 4'h1)
          reg_rdata <= {28'h0, task_code_q[reg_addr[3:0]]};
        else if (reg_addr[7:4] == 4'h2)
          reg_rdata <= {16'h0, task_mode_q[reg_addr[3:0]]};
        else if (reg_addr[7:4] == 4'h3)
          reg_rdata <= target_q[reg_addr[3:0]];
        else
        begin
          unique case (reg_addr)
            `BPBS_ADDR_CTRL:     reg_rdata <= {16'h0, drive_control_word_q};
            `BPBS_ADDR_BLKSEL:   reg_rdata <= {16'h0, block_select_word_q};
            `BPBS_ADDR_STATUS:   reg_rdata <= {16'h0, 4'h0, reference_point_reached, 11'h0} |
                                              {24'h0, missing_external_change_alarm, home_q};
            `BPBS_ADDR_HCFG:     reg_rdata <= {29'h0, alarm_is_fault_q, reversing_cam_enable_q,
                                               search_start_direction_q};
            `BPBS_ADDR_ZSPEED:   reg_rdata <= zero_mark_search_speed_q;
            `BPBS_ADDR_RSPEED:   reg_rdata <= reference_approach_speed_q;
            `BPBS_ADDR_REFCOORD: reg_rdata <= reference_coordinate_q;
            `BPBS_ADDR_REFOFS:   reg_rdata <= reference_offset_q;
            `BPBS_ADDR_ACTIVE:   reg_rdata <= {24'h0, blk_q, cur_idx_q};
            default:             reg_rdata <= 32'h0;
          endcase
        end
      end
    end
  end

endmodule

// ===== bpbs_regs.svh
`ifndef BPBS_REGS_SVH
`define BPBS_REGS_SVH

// Register indices on the plain register port
`define BPBS_ADDR_CTRL          8'h00
`define BPBS_ADDR_BLKSEL        8'h01
`define BPBS_ADDR_STATUS        8'h02
`define BPBS_ADDR_HCFG          8'h03
`define BPBS_ADDR_ZSPEED        8'h04
`define BPBS_ADDR_RSPEED        8'h05
`define BPBS_ADDR_REFCOORD      8'h06
`define BPBS_ADDR_REFOFS        8'h07
`define BPBS_ADDR_ACTIVE        8'h08
`define BPBS_ADDR_TASK_BASE     8'h10
`define BPBS_ADDR_MODE_BASE     8'h20
`define BPBS_ADDR_TARGET_BASE   8'h30

// Control, block select and status word bits
`define BPBS_CW_ACTIVATE        6
`define BPBS_CW_HOME_START      11
`define BPBS_BS_DIRECT          15
`define BPBS_SW_REF_REACHED     11

// Task mode word fields
`define BPBS_MODE_HIDE          0
`define BPBS_MODE_CONT_LSB      4
`define BPBS_MODE_POS_LSB       8

// Reset values, speed limit and block count
`define BPBS_SPEED_DEFAULT      32'h0000_012c
`define BPBS_SPEED_MAX          32'h0262_5a00
`define BPBS_NUM_BLOCKS         16

`endif

// ===== bpbs_pkg.sv
package bpbs_pkg;

  typedef enum logic [6:0] {
    BPBS_H_IDLE   = 7'b0000001,
    BPBS_H_SEARCH = 7'b0000010,
    BPBS_H_APPR   = 7'b0000100,
    BPBS_H_DONE   = 7'b0001000,
    BPBS_H_ABORT  = 7'b0010000,
    BPBS_H_RSV1   = 7'b0100000,
    BPBS_H_RSV2   = 7'b1000000
  } bpbs_home_t;

  typedef enum logic [3:0] {
    BPBS_B_IDLE = 4'b0001,
    BPBS_B_RUN  = 4'b0010,
    BPBS_B_HOLD = 4'b0100,
    BPBS_B_END  = 4'b1000
  } bpbs_blk_t;

  typedef enum logic [3:0] {
    BPBS_T_NONE = 4'h0, BPBS_T_POS = 4'h1, BPBS_T_FIXSTOP = 4'h2, BPBS_T_ENDL_POS = 4'h3,
    BPBS_T_ENDL_NEG = 4'h4, BPBS_T_WAIT = 4'h5, BPBS_T_JUMP = 4'h6, BPBS_T_SET_OUT = 4'h7,
    BPBS_T_RST_OUT = 4'h8, BPBS_T_JERK = 4'h9
  } bpbs_task_t;

  typedef enum logic [3:0] {
    BPBS_C_END = 4'h0, BPBS_C_STOP = 4'h1, BPBS_C_FLY = 4'h2, BPBS_C_EXT = 4'h3,
    BPBS_C_EXT_WAIT = 4'h4, BPBS_C_EXT_ALARM = 4'h5
  } bpbs_cont_t;

  typedef enum logic [3:0] {
    BPBS_P_ABSOLUTE = 4'h0, BPBS_P_RELATIVE = 4'h1,
    BPBS_P_ABSOLUTE_POSITIVE_APPROACH = 4'h2, BPBS_P_ABSOLUTE_NEGATIVE_APPROACH = 4'h3
  } bpbs_pmode_t;

endpackage

// ===== bpbs_motion_model.sv
module bpbs_motion_model (
  // Clock
  input  wire logic       clk_sys,
  // Feedback events asked for by the bench
  input  wire logic [8:0] ev,
  // Feedback pins
  output logic      [8:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [8:0] pin_q;

  // Sensors report one cycle after the event and fall to 0 once released
  always_ff @(posedge clk_sys)
  begin
    pin_q <= ev;
  end

  assign pins = pin_q;
endmodule

// ===== bpbs_seq_checker.sv
`include "bpbs_regs.svh"

module bpbs_seq_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // Register writes
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Feedback pins
  input wire logic        zero_mark_pin,
  input wire logic        reversing_cam_pin,
  input wire logic        referencing_cam_pin,
  input wire logic        ref_coord_reached_pin,
  input wire logic        standstill_pin,
  input wire logic        extended_telegram,
  // Motion outputs
  input wire logic        move_enable,
  input wire logic        move_negative,
  input wire logic [31:0] move_speed,
  input wire logic        stop_cams_enable,
  input wire logic        direct_setpoint_input,
  input wire logic [3:0]  active_block,
  input wire logic        reference_point_reached,
  input wire logic        missing_external_change_alarm
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  logic        wr_ctrl;
  logic [31:0] spd_d;
  logic [15:0] ctrl_q;
  logic [15:0] bsel_q;
  logic [1:0]  hcfg_q;
  logic [31:0] zs_q;
  logic [31:0] rs_q;
  logic        srch_q;

  assign wr_ctrl = reg_wr && reg_addr == `BPBS_ADDR_CTRL;
  // Speed writes land clamped into the legal range
  assign spd_d = (reg_wdata == 32'h0) ? 32'h1 : (reg_wdata > `BPBS_SPEED_MAX) ? `BPBS_SPEED_MAX : reg_wdata;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= 16'h0;
      bsel_q <= 16'h0;
      hcfg_q <= 2'h2;
      zs_q   <= `BPBS_SPEED_DEFAULT;
      rs_q   <= `BPBS_SPEED_DEFAULT;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `BPBS_ADDR_CTRL:   ctrl_q <= reg_wdata[15:0];
        `BPBS_ADDR_BLKSEL: bsel_q <= reg_wdata[15:0];
        `BPBS_ADDR_HCFG:   hcfg_q <= reg_wdata[1:0];
        `BPBS_ADDR_ZSPEED: zs_q <= spd_d;
        `BPBS_ADDR_RSPEED: rs_q <= spd_d;
        default:           ;
      endcase
    end
  end

  // Zero-mark search window, from launch to the first zero mark or a stop
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      srch_q <= 1'b0;
    else if (zero_mark_pin || (wr_ctrl && !reg_wdata[11]))
      srch_q <= 1'b0;
    else if (wr_ctrl && reg_wdata[11] && !ctrl_q[11])
      srch_q <= 1'b1;
  end

  sequence s_start;
    wr_ctrl && reg_wdata[11] && !ctrl_q[11];
  endsequence

  sequence s_search;
    srch_q && move_enable;
  endsequence

  property p_home_start;
    s_start |-> ##[1:6] move_enable && move_negative == hcfg_q[0] && move_speed == zs_q;
  endproperty
  a_home_start: assert property (p_home_start) else $error("homing launch wrong");

  property p_reverse;
    s_search ##0 ($rose(reversing_cam_pin) && hcfg_q[1]) |-> ##[1:6] move_negative != hcfg_q[0];
  endproperty
  a_reverse: assert property (p_reverse) else $error("no reversal on cam");

  property p_approach;
    s_search ##0 zero_mark_pin |-> ##[1:6] move_speed == rs_q;
  endproperty
  a_approach: assert property (p_approach) else $error("approach speed wrong");

  property p_ref_flag;
    $rose(reference_point_reached) |-> $past(ref_coord_reached_pin, 3);
  endproperty
  a_ref_flag: assert property (p_ref_flag) else $error("reference flag without arrival");

  property p_ref_hold;
    reference_point_reached && ctrl_q[11] && !wr_ctrl |=> reference_point_reached;
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference flag dropped early");

  property p_abort;
    wr_ctrl && !reg_wdata[11] && !reg_wdata[6] |-> ##[1:6] !move_enable;
  endproperty
  a_abort: assert property (p_abort) else $error("motion kept after stop");

  property p_cams_off;
    s_start ##0 !extended_telegram |-> ##[1:6] !stop_cams_enable;
  endproperty
  a_cams_off: assert property (p_cams_off) else $error("stop cams not disabled");

  property p_cams_on;
    (!extended_telegram && !stop_cams_enable && referencing_cam_pin) [*4] |-> ##[0:2] stop_cams_enable;
  endproperty
  a_cams_on: assert property (p_cams_on) else $error("stop cams not restored");

  property p_direct;
    reg_wr && reg_addr == `BPBS_ADDR_BLKSEL |-> ##2 direct_setpoint_input == bsel_q[15];
  endproperty
  a_direct: assert property (p_direct) else $error("source select wrong");

  property p_activate;
    wr_ctrl && reg_wdata[6] && !ctrl_q[6] && !bsel_q[15] |-> ##[1:6] active_block == bsel_q[3:0];
  endproperty
  a_activate: assert property (p_activate) else $error("wrong block started");

  property p_alarm;
    $rose(missing_external_change_alarm) |-> $past(standstill_pin, 3);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without standstill");
endmodule

bind bpbs_sequencer bpbs_seq_checker i_bpbs_seq_checker (
  .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .zero_mark_pin, .reversing_cam_pin, .referencing_cam_pin, .ref_coord_reached_pin,
  .standstill_pin, .extended_telegram, .move_enable, .move_negative, .move_speed,
  .stop_cams_enable, .direct_setpoint_input, .active_block, .reference_point_reached,
  .missing_external_change_alarm
);

// ===== bpbs_tb.sv
`include "bpbs_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bpbs_pkg::*;

  logic        clk_sys;
  logic        nrst;
  logic        clk_en;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [8:0]  ev;
  logic [8:0]  pins;
  logic        move_enable;
  logic        move_negative;
  logic [31:0] move_speed;
  logic        stop_cams_enable;
  logic        direct_setpoint_input;
  logic [31:0] block_target_position;
  bpbs_pmode_t block_pos_mode;
  bpbs_task_t  block_task_code;
  logic [3:0]  active_block;
  logic        reference_point_reached;
  logic        missing_external_change_alarm;
  logic        extended_telegram;
  logic [3:0]  b;
  logic [8:0]  trig;
  int          mismatches = 0;
  int          checks = 0;

  bpbs_sequencer i_bpbs_sequencer (
    .clk_sys, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .zero_mark_pin(pins[0]), .reversing_cam_pin(pins[1]), .referencing_cam_pin(pins[2]),
    .ref_coord_reached_pin(pins[3]), .braking_point_pin(pins[4]), .in_position_window_pin(pins[5]),
    .standstill_pin(pins[6]), .dir_change_needed_pin(pins[7]), .ext_block_change_pin(pins[8]),
    .extended_telegram, .move_enable, .move_negative, .move_speed, .stop_cams_enable,
    .direct_setpoint_input, .block_target_position, .block_pos_mode, .block_task_code,
    .active_block, .reference_point_reached, .missing_external_change_alarm
  );

  bpbs_motion_model i_bpbs_motion_model (.clk_sys, .ev, .pins);

  always #50 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic pin(input int i, input logic v);
    @(posedge clk_sys);
    ev[i] <= v;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    mismatches++;
    end_sim();
  end

  initial
  begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    extended_telegram = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ev = 9'h0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rdchk(`BPBS_ADDR_ZSPEED, `BPBS_SPEED_DEFAULT);
    rdchk(`BPBS_ADDR_RSPEED, `BPBS_SPEED_DEFAULT);
    rdchk(`BPBS_ADDR_HCFG, 32'h2);
    wr(`BPBS_ADDR_ZSPEED, 32'h0);
    rdchk(`BPBS_ADDR_ZSPEED, 32'h1);
    wr(`BPBS_ADDR_RSPEED, `BPBS_SPEED_MAX + 32'h1);
    rdchk(`BPBS_ADDR_RSPEED, `BPBS_SPEED_MAX);
    wr(`BPBS_ADDR_MODE_BASE, 32'hffff);
    // A write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(`BPBS_ADDR_REFOFS, 32'h77);
    clk_en <= 1'b1;
    rdchk(`BPBS_ADDR_REFOFS, 32'h0);
    rdchk(`BPBS_ADDR_MODE_BASE, 32'h0fff);
    wr(8'hff, 32'h1234);
    rdchk(8'hff, 32'h0);
    // Homing in both start directions, with one cam reversal each
    for (int d = 0; d < 2; d++)
    begin
      wr(`BPBS_ADDR_HCFG, {30'h0, 1'b1, d[0]});
      wr(`BPBS_ADDR_ZSPEED, 32'h100 + 32'(d));
      wr(`BPBS_ADDR_RSPEED, 32'h200 + 32'(d));
      wr(`BPBS_ADDR_CTRL, 32'h800);
      wt(6);
      chk(32'(move_enable), 32'h1);
      chk(32'(move_negative), 32'(d));
      chk(move_speed, 32'h100 + 32'(d));
      chk(32'(stop_cams_enable), 32'h0);
      pin(1, 1'b1);
      pin(1, 1'b0);
      wt(6);
      chk(32'(move_negative), 32'(!d[0]));
      pin(2, 1'b1);
      wt(6);
      chk(32'(stop_cams_enable), 32'h1);
      pin(2, 1'b0);
      pin(0, 1'b1);
      pin(0, 1'b0);
      wt(6);
      chk(move_speed, 32'h200 + 32'(d));
      pin(3, 1'b1);
      wt(6);
      rdchk(`BPBS_ADDR_STATUS, 32'h808);
      wr(`BPBS_ADDR_CTRL, 32'h0);
      pin(3, 1'b0);
      wt(4);
      chk(32'(reference_point_reached), 32'h0);
    end
    wr(`BPBS_ADDR_CTRL, 32'h800);
    wt(6);
    wr(`BPBS_ADDR_CTRL, 32'h0);
    wt(4);
    chk(32'(move_enable), 32'h0);
    chk(32'(stop_cams_enable), 32'h1);
    rdchk(`BPBS_ADDR_STATUS, 32'h1);
    // Extended telegram: the stop cams stay with the controller
    @(posedge clk_sys);
    extended_telegram <= 1'b1;
    wr(`BPBS_ADDR_CTRL, 32'h800);
    wt(6);
    chk(32'(move_enable), 32'h1);
    chk(32'(stop_cams_enable), 32'h1);
    wr(`BPBS_ADDR_CTRL, 32'h0);
    extended_telegram <= 1'b0;
    // Task codes 1 to 9 and every positioning mode, block 16 last
    for (int i = 0; i < 10; i++)
    begin
      b = (i == 9) ? 4'hf : i[3:0];
      wr(`BPBS_ADDR_TASK_BASE + 8'(b), 32'(i % 9 + 1));
      wr(`BPBS_ADDR_MODE_BASE + 8'(b), 32'(i % 4) << 8);
      wr(`BPBS_ADDR_TARGET_BASE + 8'(b), 32'h111 * 32'(i));
      wr(`BPBS_ADDR_BLKSEL, 32'(b));
      wr(`BPBS_ADDR_CTRL, 32'h40);
      wt(6);
      wr(`BPBS_ADDR_TARGET_BASE + 8'(b), 32'h5a5a);
      chk(32'(active_block), 32'(b));
      chk(32'(block_task_code), 32'(i % 9 + 1));
      chk(32'(block_pos_mode), 32'(i % 4));
      chk(block_target_position, 32'h111 * 32'(i));
      wr(`BPBS_ADDR_CTRL, 32'h0);
      wt(4);
      chk(32'(move_enable), 32'h0);
    end
    wr(`BPBS_ADDR_MODE_BASE + 8'hf, 32'h1);
    wr(`BPBS_ADDR_CTRL, 32'h40);
    wt(6);
    chk(32'(move_enable), 32'h0);
    wr(`BPBS_ADDR_CTRL, 32'h0);
    wr(`BPBS_ADDR_BLKSEL, 32'h8000);
    wt(2);
    chk(32'(direct_setpoint_input), 32'h1);
    wr(`BPBS_ADDR_CTRL, 32'h40);
    wt(6);
    chk(32'(move_enable), 32'h0);
    wr(`BPBS_ADDR_CTRL, 32'h0);
    wr(`BPBS_ADDR_BLKSEL, 32'h4);
    wt(2);
    chk(32'(direct_setpoint_input), 32'h0);
    // Continuation conditions from block 5 into block 6
    wr(`BPBS_ADDR_TASK_BASE + 8'h4, 32'h1);
    wr(`BPBS_ADDR_TASK_BASE + 8'h5, 32'h1);
    wr(`BPBS_ADDR_MODE_BASE + 8'h5, 32'h0);
    wr(`BPBS_ADDR_HCFG, 32'h6);
    for (int c = 1; c < 6; c++)
    begin
      trig = (c == 1) ? 9'h060 : (c == 2) ? 9'h010 : (c == 5) ? 9'h040 : 9'h100;
      wr(`BPBS_ADDR_MODE_BASE + 8'h4, 32'(c) << 4);
      wr(`BPBS_ADDR_CTRL, 32'h40);
      wt(6);
      chk(32'(active_block), 32'h4);
      ev <= trig;
      wt(8);
      ev <= 9'h0;
      chk(32'(active_block), (c == 5) ? 32'h4 : 32'h5);
      chk(32'(missing_external_change_alarm), 32'(c == 5));
      rdchk(`BPBS_ADDR_ACTIVE, (c == 1) ? 32'h85 : (c == 5) ? 32'h14 : 32'h25);
      wr(`BPBS_ADDR_CTRL, 32'h0);
      wt(4);
    end
    end_sim();
  end
endmodule
